//--- two_wire_pkg.sv
// shared constants for the two-wire serial slave port and its bus master
// assumes both ends run on one core clock of 25 MHz
`default_nettype none
package two_wire_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam int BYTE_BITS = 8;
  localparam int CORE_CLK_MHZ = 25;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS * CORE_CLK_MHZ) / 2000;
  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
endpackage : two_wire_pkg
`default_nettype wire

//--- two_wire_if.sv
// two-wire bus wires between the serial slave port and its master
// open-drain: a line is low when any end enables its pull-down
`default_nettype none
interface two_wire_if;
  logic sclOe_n;
  logic sdaMstOe_n;
  logic sdaSlvOe_n;
  logic scl;
  logic sda;
  assign scl = sclOe_n;
  assign sda = sdaMstOe_n & sdaSlvOe_n;
  modport slave (input scl, input sda, output sdaSlvOe_n);
  modport master (input scl, input sda, output sclOe_n, output sdaMstOe_n);
endinterface : two_wire_if
`default_nettype wire

//--- stream_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock shared by writer and reader
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  import two_wire_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic doWr, doRd;
  always_comb begin
    inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
    outValid = wrPtr_r != rdPtr_r;
    outData = mem[rdPtr_r[AW-1:0]];
    doWr = inValid && inReady;
    doRd = outValid && outReady;
    wrPtr_nxt = doWr ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = doRd ? rdPtr_r + 1'b1 : rdPtr_r;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
    if (doWr) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
endmodule : stream_fifo
`default_nettype wire

//--- two_wire_slave.sv
// serial slave port: recognises its address, receives and sends bytes
// assumes scl/sda come from the far end, sampled on core_clk
// Overview of operation
// R1 - one bit per clock pulse, stable high
// R2 - falling data while clock high starts
// R3 - rising data while clock high stops
// R4 - master never sends repeated start
// R5 - master starts only on idle bus
// R6 - slave only, never drives clock
// R7 - eight bits then one acknowledge slot
// R8 - acknowledge every received byte when addressed
// R9 - master acknowledges read bytes except last
// R10 - acknowledger holds data low whole pulse
// R11 - no acknowledge ends read, release line
// R12 - address byte follows every start
// R13 - answer only address 1010001, msb first
// R14 - address bit zero: one read, zero write
// R15 - writes end with stop only
// R16 - ignore bus while on battery
// R17 - master finishes before battery switchover
// R18 - raise power fail on falling supply
// R19 - master resyncs with stop then start
// R20 - first write byte sets register pointer
// R21 - wrong address: no acknowledge, idle
`default_nettype none
module two_wire_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  two_wire_if.slave bus,
  input wire logic backup_battery_supply,
  input wire logic supplyFalling,
  output logic power_fail_output,
  output logic [7:0] wrData,
  output logic [7:0] wrPtr,
  output logic wrValid,
  input wire logic wrReady,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  output logic rdReady,
  output logic [7:0] regPtr
);
  import two_wire_pkg::*;
  typedef enum {IDLE, ADDR, WRPTR, WRDATA, ACKW, RDBITS, RDACK} st_e;
  st_e st_r, st_nxt;
  logic [2:0] sclSync_r, sdaSync_r;
  logic sclLvl_r, sdaLvl_r, sclLvl_nxt, sdaLvl_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic isRead_r, isRead_nxt, gotPtr_r, gotPtr_nxt;
  logic oe_n_r, oe_n_nxt, pf_r, pf_nxt, wv_r, wv_nxt;
  logic [7:0] wd_r, wd_nxt, wp_r, wp_nxt;
  logic sclRise, sclFall, startCond, stopCond;
  logic [7:0] fifoData;
  logic fifoValid, fifoReady, popRd;

  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rdFifo (
    .core_clk(core_clk), .rst_n(rst_n),
    .inData(rdData), .inValid(rdValid), .inReady(rdReady),
    .outData(fifoData), .outValid(fifoValid), .outReady(popRd)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
    end else begin
      sclSync_r <= {sclSync_r[1:0], bus.scl};
      sdaSync_r <= {sdaSync_r[1:0], bus.sda};
    end
  end

  always_comb begin
    sclLvl_nxt = (sclSync_r[1] == sclSync_r[2]) ? sclSync_r[2] : sclLvl_r;
    sdaLvl_nxt = (sdaSync_r[1] == sdaSync_r[2]) ? sdaSync_r[2] : sdaLvl_r;
    sclRise = sclLvl_nxt && !sclLvl_r;
    sclFall = !sclLvl_nxt && sclLvl_r;
    // R2 start detect
    startCond = sclLvl_r && sclLvl_nxt && sdaLvl_r && !sdaLvl_nxt;
    // R3 stop detect
    stopCond = sclLvl_r && sclLvl_nxt && !sdaLvl_r && sdaLvl_nxt;
    st_nxt = st_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    isRead_nxt = isRead_r;
    gotPtr_nxt = gotPtr_r;
    oe_n_nxt = oe_n_r;
    wd_nxt = wd_r;
    wp_nxt = wp_r;
    wv_nxt = wv_r && !wrReady;
    popRd = 1'b0;
    // R18 power fail warning
    pf_nxt = supplyFalling || backup_battery_supply;
    if (backup_battery_supply) begin
      // R16 ignore bus on battery
      st_nxt = IDLE;
      oe_n_nxt = 1'b1;
    end else if (stopCond) begin
      // R3 back to idle
      st_nxt = IDLE;
      oe_n_nxt = 1'b1;
    end else if (startCond) begin
      // R2 watch for address
      st_nxt = ADDR;
      cnt_nxt = BIT_CNT_RESET;
      gotPtr_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (st_r)
        IDLE: ;
        ADDR, WRPTR, WRDATA: begin
          // R1 sample on rising clock
          if (sclRise && cnt_r < 4'(BYTE_BITS)) begin
            shift_nxt = {shift_r[6:0], sdaLvl_nxt};
            cnt_nxt = cnt_r + 4'h1;
          end
          // R7 ack slot after eight bits
          if (sclFall && cnt_r == 4'(BYTE_BITS)) begin
            if (st_r == ADDR) begin
              // R13 own address only
              if (shift_r[7:1] == DEV_ADDR) begin
                // R8 acknowledge address
                oe_n_nxt = 1'b0;
                // R14 direction bit
                isRead_nxt = shift_r[0];
                st_nxt = ACKW;
              end else begin
                // R21 no ack, idle
                st_nxt = IDLE;
              end
            end else begin
              // R8 acknowledge data byte
              oe_n_nxt = 1'b0;
              st_nxt = ACKW;
              if (!gotPtr_r) begin
                // R20 pointer byte
                ptr_nxt = shift_r;
                gotPtr_nxt = 1'b1;
              end else begin
                wd_nxt = shift_r;
                wp_nxt = ptr_r;
                wv_nxt = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        ACKW: begin
          // R10 hold low through pulse
          if (sclFall) begin
            cnt_nxt = BIT_CNT_RESET;
            if (isRead_r) begin
              shift_nxt = fifoValid ? fifoData : 8'hff;
              popRd = fifoValid;
              ptr_nxt = ptr_r + 8'h01;
              oe_n_nxt = fifoValid ? fifoData[7] : 1'b1;
              cnt_nxt = 4'h1;
              st_nxt = RDBITS;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt = gotPtr_r ? WRDATA : WRPTR;
            end
          end
        end
        RDBITS: begin
          if (sclFall) begin
            if (cnt_r == 4'(BYTE_BITS)) begin
              oe_n_nxt = 1'b1;
              st_nxt = RDACK;
            end else begin
              oe_n_nxt = shift_r[7 - cnt_r[2:0]];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        RDACK: begin
          if (sclRise) begin
            // R11 nack releases line
            if (sdaLvl_nxt) begin
              st_nxt = IDLE;
            end else begin
              st_nxt = ACKW;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclLvl_r <= 1'b1;
      sdaLvl_r <= 1'b1;
      st_r <= IDLE;
      shift_r <= '0;
      cnt_r <= BIT_CNT_RESET;
      ptr_r <= PTR_RESET;
      isRead_r <= 1'b0;
      gotPtr_r <= 1'b0;
      oe_n_r <= 1'b1;
      pf_r <= 1'b0;
      wd_r <= '0;
      wp_r <= '0;
      wv_r <= 1'b0;
    end else begin
      sclLvl_r <= sclLvl_nxt;
      sdaLvl_r <= sdaLvl_nxt;
      st_r <= st_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      isRead_r <= isRead_nxt;
      gotPtr_r <= gotPtr_nxt;
      oe_n_r <= oe_n_nxt;
      pf_r <= pf_nxt;
      wd_r <= wd_nxt;
      wp_r <= wp_nxt;
      wv_r <= wv_nxt;
    end
  end

  // R6 drives data only, never clock
  assign bus.sdaSlvOe_n = oe_n_r;
  assign power_fail_output = pf_r;
  assign wrData = wd_r;
  assign wrPtr = wp_r;
  assign wrValid = wv_r;
  assign regPtr = ptr_r;
endmodule : two_wire_slave
`default_nettype wire

//--- two_wire_master.sv
// bus master end: one write or read transfer per command
// assumes the slave end samples scl/sda with its own core clock
`default_nettype none
module two_wire_master (
  input wire logic core_clk,
  input wire logic rst_n,
  two_wire_if.master bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [6:0] cmdAddr,
  input wire logic [7:0] cmdPtr,
  input wire logic [7:0] cmdData,
  output logic [7:0] rspData,
  output logic rspValid,
  output logic rspAck
);
  import two_wire_pkg::*;
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mst_e;
  mst_e st_r, st_nxt;
  logic [7:0] half_r, half_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] byte_r, byte_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt, rv_r, rv_nxt, ack_r, ack_nxt;
  logic rd_r, rd_nxt, tick;
  logic [7:0] d_r, d_nxt;
  always_comb begin
    tick = half_r == 8'(LINK_HALF_CYC - 1);
    half_nxt = tick ? 8'h00 : half_r + 8'h01;
    st_nxt = st_r;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    rv_nxt = 1'b0;
    ack_nxt = ack_r;
    rd_nxt = rd_r;
    d_nxt = d_r;
    cmdReady = st_r == M_IDLE;
    unique case (st_r)
      M_IDLE: if (cmdValid) begin
        // R5 starts from idle bus
        st_nxt = M_START;
        rd_nxt = cmdRead;
        d_nxt = cmdData;
        // R12 address byte right after start
        tx_nxt = {cmdAddr, cmdRead};
        byte_nxt = 2'h0;
        ph_nxt = 2'h0;
        half_nxt = 8'h00;
      end
      M_START: if (tick) begin
        // R2 data falls with clock high
        sda_nxt = 1'b0;
        st_nxt = M_BIT;
        bit_nxt = 4'h0;
        ph_nxt = 2'h0;
      end
      M_BIT: if (tick) begin
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b0;
        end else if (ph_r == 2'h1) begin
          // R1 data changes while clock low
          if (bit_r < 4'(BYTE_BITS)) begin
            sda_nxt = (rd_r && byte_r != 2'h0) ? 1'b1 : tx_r[7 - bit_r[2:0]];
          end else begin
            // R9 release: slave acks, or nack ends read
            sda_nxt = 1'b1;
          end
        end else if (ph_r == 2'h2) begin
          scl_nxt = 1'b1;
        end else begin
          if (bit_r < 4'(BYTE_BITS)) begin
            rx_nxt = {rx_r[6:0], bus.sda};
            bit_nxt = bit_r + 4'h1;
          end else begin
            if (!(rd_r && byte_r != 2'h0)) begin
              ack_nxt = !bus.sda;
            end
            bit_nxt = 4'h0;
            byte_nxt = byte_r + 2'h1;
            if (!ack_nxt || (rd_r && byte_r == 2'h1) ||
                (!rd_r && byte_r == 2'h2)) begin
              st_nxt = M_STOP;
              ph_nxt = 2'h0;
            end
            tx_nxt = byte_r == 2'h0 ? cmdPtr : d_r;
          end
        end
      end
      M_STOP: if (tick) begin
        // R4 stop before any next start
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b0;
        end else if (ph_r == 2'h1) begin
          sda_nxt = 1'b0;
        end else if (ph_r == 2'h2) begin
          scl_nxt = 1'b1;
        end else begin
          // R15 write ends with stop
          sda_nxt = 1'b1;
          st_nxt = M_IDLE;
          rv_nxt = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= M_IDLE;
      half_r <= 8'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      rv_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      d_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      rv_r <= rv_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      d_r <= d_nxt;
    end
  end
  assign bus.sclOe_n = scl_r;
  assign bus.sdaMstOe_n = sda_r;
  assign rspData = rx_r;
  assign rspValid = rv_r;
  assign rspAck = ack_r;
endmodule : two_wire_master
`default_nettype wire

//--- two_wire_checker.sv
// checker on the two-wire link between slave and master ends
// assumes one core clock and a synchronous active-low reset
`default_nettype none
module two_wire_checker
  import two_wire_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclOe_n,
  input wire logic sdaMstOe_n,
  input wire logic sdaSlvOe_n,
  input wire logic scl,
  input wire logic sda
);
  import two_wire_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic sclD_r, sdaD_r, busy_r, rdMode_r, firstByte_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  wire logic sclRise = scl & ~sclD_r;
  wire logic startEv = scl & sclD_r & sdaD_r & ~sda;
  wire logic stopEv = scl & sclD_r & ~sdaD_r & sda;
  // count clock pulses since start, 9 per byte
  always_ff @(posedge core_clk) begin
    sclD_r <= scl;
    sdaD_r <= sda;
    if (!rst_n || stopEv || startEv) begin
      busy_r <= startEv & rst_n;
      cnt_r <= 4'h0;
      firstByte_r <= startEv & rst_n;
      rdMode_r <= 1'h0;
    end else if (sclRise && busy_r) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r == 4'h9) firstByte_r <= 1'h0;
      if (cnt_r < 4'h8 || cnt_r == 4'h9) shift_r <= {shift_r[6:0], sda};
      if (firstByte_r && cnt_r == 4'h7) rdMode_r <= sda;
    end
  end
  sequence startSeq;
    startEv;
  endsequence
  sequence stopSeq;
    stopEv;
  endsequence
  sequence ackSlot;
    sclRise && cnt_r == 4'h8;
  endsequence
  AST_SLV_SCL_LOW: assert property ($changed(sdaSlvOe_n) |-> !scl)
    else $error("slave data moved while clock high");
  AST_NO_SLV_START: assert property (startSeq |-> sdaSlvOe_n)
    else $error("slave took part in a start");
  AST_START_RELEASED: assert property (startSeq |=> sdaSlvOe_n [*8])
    else $error("slave drove data right after start");
  AST_STOP_IDLE: assert property (stopSeq |=> sdaSlvOe_n [*8])
    else $error("slave drove data after stop");
  AST_NO_RESTART: assert property (startSeq |-> !busy_r)
    else $error("repeated start issued");
  AST_IDLE_START: assert property (startSeq |-> $past(scl, 2))
    else $error("start without idle clock");
  AST_ACK_HOLD: assert property (
    scl && !sdaSlvOe_n |=> !scl || !sdaSlvOe_n)
    else $error("slave let go of data while clock high");
  AST_ADDR_NACK: assert property (ackSlot ##0
    (firstByte_r && shift_r[7:1] != DEV_ADDR) |-> sdaSlvOe_n)
    else $error("slave answered a foreign address");
  AST_READ_RELEASE: assert property (ackSlot ##0
    (rdMode_r && !firstByte_r && sda) |=> sdaSlvOe_n [*8])
    else $error("slave kept data after no-acknowledge");
  AST_WRITE_RELEASED: assert property (sclRise && busy_r
    && !rdMode_r && cnt_r != 4'h8 |-> sdaSlvOe_n)
    else $error("slave drove a bit in write direction");
  AST_MST_ACK_SLOT: assert property (ackSlot |-> sdaMstOe_n)
    else $error("master drove data in an acknowledge slot");
  AST_MST_SDA_STABLE: assert property (sclOe_n && $changed(sdaMstOe_n)
    |-> startEv || stopEv)
    else $error("master moved data while clock high");
endmodule : two_wire_checker
`default_nettype wire

//--- rtc_two_wire_slave_port_test.sv
// bench: master end drives the slave end over one link, model compares
// assumes the shared two-wire package and a 25 MHz core clock
`default_nettype none
module rtc_two_wire_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import two_wire_pkg::*;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic onBattery = 1'h0, supplyFalling = 1'h0, powerFail;
  logic [7:0] wrData, wrPtr, rdData = 8'h00, regPtr, rspData;
  logic wrValid, wrReady = 1'h0, rdValid = 1'h0, rdReady;
  logic cmdValid = 1'h0, cmdReady, cmdRead = 1'h0, rspValid, rspAck;
  logic [6:0] cmdAddr = 7'h00;
  logic [7:0] cmdPtr = 8'h00, cmdData = 8'h00, expPtr = PTR_RESET;
  logic [15:0] wrQ[$];
  logic [7:0] rdQ[$];
  int miscompares = 0, checks = 0, cycles = 0, seed = 32'h720e089d;
  always #20 core_clk = ~core_clk;
  two_wire_if link ();
  two_wire_slave two_wire_slave_inst (.core_clk(core_clk), .rst_n(rst_n),
    .bus(link.slave), .backup_battery_supply(onBattery),
    .supplyFalling(supplyFalling), .power_fail_output(powerFail),
    .wrData(wrData), .wrPtr(wrPtr), .wrValid(wrValid), .wrReady(wrReady),
    .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .regPtr(regPtr));
  two_wire_master two_wire_master_inst (.core_clk(core_clk),
    .rst_n(rst_n), .bus(link.master), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
    .cmdPtr(cmdPtr), .cmdData(cmdData), .rspData(rspData),
    .rspValid(rspValid), .rspAck(rspAck));
  two_wire_checker two_wire_checker_inst (.core_clk(core_clk),
    .rst_n(rst_n), .sclOe_n(link.sclOe_n), .sdaMstOe_n(link.sdaMstOe_n),
    .sdaSlvOe_n(link.sdaSlvOe_n), .scl(link.scl), .sda(link.sda));
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chkBit
  task automatic xfer(input logic rd, input logic [6:0] addr,
      input logic [7:0] ptr, input logic [7:0] data);
    int n;
    @(negedge core_clk);
    cmdValid = 1'h1;
    cmdRead = rd;
    cmdAddr = addr;
    cmdPtr = ptr;
    cmdData = data;
    n = 0;
    // ready seen on a falling edge: the next rising edge takes the command
    while (cmdReady !== 1'h1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    cmdValid = 1'h0;
    n = 0;
    while (rspValid !== 1'h1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (rspValid !== 1'h1) begin
      miscompares++;
      $display("[FAIL] %0t transfer never finished", $time);
    end
  endtask : xfer
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      $display("[FAIL] %0t run too long", $time);
      test_done();
    end
  end
  // register sink stalls at random
  always @(negedge core_clk) wrReady <= 1'($random(seed));
  always @(posedge core_clk) begin
    if (rst_n && wrValid === 1'h1 && wrReady) begin
      if (wrQ.size() == 0) begin
        chkBit(1'h1, 1'h0);
      end else begin
        chkByte(wrPtr, wrQ[0][15:8]);
        chkByte(wrData, wrQ[0][7:0]);
        void'(wrQ.pop_front());
      end
    end
  end
  initial begin
    int i;
    logic [7:0] p, d;
    repeat (4) @(negedge core_clk);
    rst_n = 1'h1;
    for (i = 0; i < 6; i++) begin
      p = (i == 0) ? 8'hff : 8'($random(seed));
      d = 8'($random(seed));
      wrQ.push_back({p, d});
      xfer(1'h0, DEV_ADDR, p, d);
      chkBit(rspAck, 1'h1);
      expPtr = p + 8'h01;
      chkByte(regPtr, expPtr);
    end
    for (i = 0; i < 8; i++) begin
      xfer(i == 7, DEV_ADDR ^ 7'(1 << (i % 7)), 8'h3c, 8'h5a);
      chkBit(rspAck, 1'h0);
      chkByte(regPtr, expPtr);
    end
    i = 0;
    while (rdReady === 1'h1 && i < 40) begin
      rdData = 8'($random(seed));
      rdValid = 1'h1;
      @(posedge core_clk);
      rdQ.push_back(rdData);
      i++;
      @(negedge core_clk);
    end
    rdValid = 1'h0;
    chkByte(8'(i), 8'(FIFO_DEPTH));
    for (i = 0; i <= FIFO_DEPTH; i++) begin
      d = (rdQ.size() > 0) ? rdQ.pop_front() : 8'hff;
      xfer(1'h1, DEV_ADDR, 8'h00, 8'h00);
      chkByte(rspData, d);
      expPtr = expPtr + 8'h01;
      chkByte(regPtr, expPtr);
    end
    onBattery = 1'h1;
    repeat (2) @(negedge core_clk);
    chkBit(powerFail, 1'h1);
    xfer(1'h0, DEV_ADDR, 8'h11, 8'h22);
    chkBit(rspAck, 1'h0);
    onBattery = 1'h0;
    supplyFalling = 1'h1;
    repeat (2) @(negedge core_clk);
    chkBit(powerFail, 1'h1);
    supplyFalling = 1'h0;
    repeat (2) @(negedge core_clk);
    chkBit(powerFail, 1'h0);
    wrQ.push_back(16'h4477);
    xfer(1'h0, DEV_ADDR, 8'h44, 8'h77);
    chkBit(rspAck, 1'h1);
    chkByte(regPtr, 8'h45);
    repeat (20) @(negedge core_clk);
    chkByte(8'(wrQ.size()), 8'h00);
    test_done();
  end
endmodule : rtc_two_wire_slave_port_test
`default_nettype wire
